// [rtl/bvs_setpoint_regs.sv]
// Setpoint control registers of three step-down converters behind a two-wire serial slave.
// Assumes an external open-drain bus: the pad pulls the data line low while sda_oe_o is high.
// Operation
// - Bit 7 picks register code (0) or external adjustment (1).
// - Bit 6 is reserved, read-only, reads as zero.
// - Codes 0-23 give 0.9 V + 25 mV steps; 24-47 give 1.5 V + 50 mV.
// - Codes 48-55 map 2.7 to 3.2 V; codes 56-63 all give 3.3 V.
// - First converter code uses the common table, 0.9 V at code zero.
// - Second converter code uses the common table, 0.9 V at code zero.
// - Third converter register resets to 0x08, register mode, 1.1 V.
// - Second converter resets to 3.3 V on variant 0, 1.1 V otherwise.
// - First converter resets 1.8 V on variants 0-1, 1.5 V on variant 2.
// - Setpoint registers are write-protected; each write needs a prior unlock.
// - Key 0x7D allows exactly one following protected write; other values lock.
// - Unlock register clears after the transaction following the one writing it.
`timescale 1ns/1ps
`default_nettype none
module bvs_setpoint_regs #(
    parameter int VARIANT = 0
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic buck1_external_adjust_o,
    output logic [5:0] buck1_voltage_code_o,
    output logic [11:0] buck1_voltage_mv_o,
    output logic buck2_external_adjust_o,
    output logic [5:0] buck2_voltage_code_o,
    output logic [11:0] buck2_voltage_mv_o,
    output logic buck3_external_adjust_o,
    output logic [5:0] buck3_voltage_code_o,
    output logic [11:0] buck3_voltage_mv_o
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_DEV, ST_DEV_ACK, ST_REG, ST_REG_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } bvs_state_e;

    // ***********************************************************
    // Pin synchronisers and bus conditions
    // ***********************************************************
    logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
        end
    end

    assign scl_rise = scl_s2_r & ~scl_d_r;
    assign scl_fall = ~scl_s2_r & scl_d_r;
    assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

    // ***********************************************************
    // Serial slave and register file
    // ***********************************************************
    localparam logic [7:0] BUCK1_RST = bvs_pkg::BVS_BUCK1_RST[VARIANT];
    localparam logic [7:0] BUCK2_RST = bvs_pkg::BVS_BUCK2_RST[VARIANT];

    bvs_state_e state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt, key_r, key_nxt;
    logic rw_r, rw_nxt, mack_r, mack_nxt, fresh_r, fresh_nxt, open_r, open_nxt;
    logic sda_oe_r, sda_oe_nxt;
    logic [7:0] sp_r [0:2];
    logic [7:0] sp_nxt [0:2];
    logic txn_end, wr_commit, ptr_prot, unlocked;
    logic [1:0] ptr_idx;
    logic [2:0] adj_vec;
    // Read data seen through the pointer; unmapped offsets read as zero
    function automatic logic [7:0] rd_mux(input logic [7:0] p, input logic [7:0] s0,
                                          input logic [7:0] s1, input logic [7:0] s2,
                                          input logic [7:0] k);
        case (p)
            bvs_pkg::BVS_OFS_BUCK1: return s0;
            bvs_pkg::BVS_OFS_BUCK2: return s1;
            bvs_pkg::BVS_OFS_BUCK3: return s2;
            bvs_pkg::BVS_OFS_UNLOCK: return k;
            default: return 8'h00;
        endcase
    endfunction
    assign txn_end = stop_det | (start_det & open_r);
    assign ptr_prot = (ptr_r >= bvs_pkg::BVS_OFS_BUCK1) && (ptr_r <= bvs_pkg::BVS_OFS_BUCK3);
    assign ptr_idx = 2'(ptr_r - bvs_pkg::BVS_OFS_BUCK1);
    assign unlocked = (key_r == bvs_pkg::BVS_UNLOCK_KEY);
    assign wr_commit = ~start_det & ~stop_det & ~scl_rise & scl_fall & (state_r == ST_WR)
                       & (cnt_r == bvs_pkg::BVS_BITS_PER_BYTE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        ptr_nxt = ptr_r;
        key_nxt = key_r;
        rw_nxt = rw_r;
        mack_nxt = mack_r;
        fresh_nxt = fresh_r;
        open_nxt = open_r;
        sp_nxt = sp_r;
        if (txn_end) begin
            // A key survives the end of its own transaction and dies at the next one
            if (fresh_r) begin
                fresh_nxt = 1'b0;
            end else begin
                key_nxt = bvs_pkg::BVS_UNLOCK_RST;
            end
        end
        if (start_det) begin
            state_nxt = ST_DEV;
            cnt_nxt = 4'h0;
            open_nxt = 1'b1;
        end else if (stop_det) begin
            state_nxt = ST_IDLE;
            open_nxt = 1'b0;
        end else if (scl_rise) begin
            case (state_r)
                ST_DEV, ST_REG, ST_WR: begin
                    sh_nxt = {sh_r[6:0], sda_s2_r};
                    cnt_nxt = 4'(cnt_r + 4'h1);
                end
                ST_RD_ACK: mack_nxt = ~sda_s2_r;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state_r)
                ST_DEV: begin
                    if (cnt_r == bvs_pkg::BVS_BITS_PER_BYTE) begin
                        cnt_nxt = 4'h0;
                        rw_nxt = sh_r[0];
                        state_nxt = (sh_r[7:1] == bvs_pkg::BVS_DEV_ADDR) ? ST_DEV_ACK : ST_IDLE;
                    end
                end
                ST_DEV_ACK: begin
                    tx_nxt = rd_mux(ptr_r, sp_r[0], sp_r[1], sp_r[2], key_r);
                    state_nxt = rw_r ? ST_RD : ST_REG;
                end
                ST_REG: begin
                    if (cnt_r == bvs_pkg::BVS_BITS_PER_BYTE) begin
                        cnt_nxt = 4'h0;
                        ptr_nxt = sh_r;
                        state_nxt = ST_REG_ACK;
                    end
                end
                ST_REG_ACK: state_nxt = ST_WR;
                ST_WR: begin
                    if (cnt_r == bvs_pkg::BVS_BITS_PER_BYTE) begin
                        cnt_nxt = 4'h0;
                        ptr_nxt = 8'(ptr_r + 8'h01);
                        state_nxt = ST_WR_ACK;
                        if (ptr_r == bvs_pkg::BVS_OFS_UNLOCK) begin
                            key_nxt = sh_r;
                            fresh_nxt = 1'b1;
                        end else if (ptr_prot && unlocked) begin
                            sp_nxt[ptr_idx] = sh_r & bvs_pkg::BVS_WR_MASK;
                            key_nxt = bvs_pkg::BVS_UNLOCK_RST;
                        end
                    end
                end
                ST_WR_ACK: state_nxt = ST_WR;
                ST_RD: begin
                    tx_nxt = {tx_r[6:0], 1'b0};
                    cnt_nxt = 4'(cnt_r + 4'h1);
                    if (cnt_r == 4'h7) begin
                        cnt_nxt = 4'h0;
                        ptr_nxt = 8'(ptr_r + 8'h01);
                        state_nxt = ST_RD_ACK;
                    end
                end
                ST_RD_ACK: begin
                    tx_nxt = rd_mux(ptr_r, sp_r[0], sp_r[1], sp_r[2], key_r);
                    state_nxt = mack_r ? ST_RD : ST_IDLE;
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
        // Registered pull-down keeps the pad free of decode glitches
        sda_oe_nxt = (state_nxt == ST_DEV_ACK) || (state_nxt == ST_REG_ACK) || (state_nxt == ST_WR_ACK)
                     || ((state_nxt == ST_RD) && !tx_nxt[7]);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            key_r <= bvs_pkg::BVS_UNLOCK_RST;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            fresh_r <= 1'b0;
            open_r <= 1'b0;
            sda_oe_r <= 1'b0;
            sp_r[0] <= BUCK1_RST;
            sp_r[1] <= BUCK2_RST;
            sp_r[2] <= bvs_pkg::BVS_BUCK3_RST;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            ptr_r <= ptr_nxt;
            key_r <= key_nxt;
            rw_r <= rw_nxt;
            mack_r <= mack_nxt;
            fresh_r <= fresh_nxt;
            open_r <= open_nxt;
            sda_oe_r <= sda_oe_nxt;
            sp_r <= sp_nxt;
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_r;

    // ***********************************************************
    // Converter outputs
    // ***********************************************************
    assign buck1_external_adjust_o = sp_r[0][bvs_pkg::BVS_EXT_ADJ_BIT];
    assign buck2_external_adjust_o = sp_r[1][bvs_pkg::BVS_EXT_ADJ_BIT];
    assign buck3_external_adjust_o = sp_r[2][bvs_pkg::BVS_EXT_ADJ_BIT];
    assign buck1_voltage_code_o = sp_r[0][5:0];
    assign buck2_voltage_code_o = sp_r[1][5:0];
    assign buck3_voltage_code_o = sp_r[2][5:0];

    bvs_code_to_mv u_dec1 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .code_i(sp_r[0][5:0]),
                           .mv_o(buck1_voltage_mv_o));
    bvs_code_to_mv u_dec2 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .code_i(sp_r[1][5:0]),
                           .mv_o(buck2_voltage_mv_o));
    bvs_code_to_mv u_dec3 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .code_i(sp_r[2][5:0]),
                           .mv_o(buck3_voltage_mv_o));

    // ***********************************************************
    // Checks
    // ***********************************************************
    sequence s_locked_wr;
        wr_commit && ptr_prot && !unlocked;
    endsequence
    sequence s_unlocked_wr;
        wr_commit && ptr_prot && unlocked;
    endsequence
    assign adj_vec = {buck3_external_adjust_o, buck2_external_adjust_o, buck1_external_adjust_o};
    property p_ext_adj;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            s_unlocked_wr |=> adj_vec[$past(ptr_idx)] == $past(sh_r[bvs_pkg::BVS_EXT_ADJ_BIT]);
    endproperty
    a_ext_adj: assert property (p_ext_adj) else $error("external adjust output mismatch");
    property p_rsvd_zero;
        @(posedge clk_sys_i) disable iff (!rst_n_i) !sp_r[0][6] && !sp_r[1][6] && !sp_r[2][6];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");
    property p_buck1_tbl;
        @(posedge clk_sys_i) disable iff (!rst_n_i) (sp_r[0][5:0] == 6'h00) [*2] |-> buck1_voltage_mv_o == 12'h384;
    endproperty
    a_buck1_tbl: assert property (p_buck1_tbl) else $error("buck1 code 0 not 0.9 V");
    property p_buck2_tbl;
        @(posedge clk_sys_i) disable iff (!rst_n_i) (sp_r[1][5:0] == 6'h00) [*2] |-> buck2_voltage_mv_o == 12'h384;
    endproperty
    a_buck2_tbl: assert property (p_buck2_tbl) else $error("buck2 code 0 not 0.9 V");
    property p_rst_vals;
        @(posedge clk_sys_i) $past(!rst_n_i) && rst_n_i |->
            sp_r[2] == 8'h08 && sp_r[1] == BUCK2_RST && sp_r[0] == BUCK1_RST;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("wrong setpoint reset value");
    property p_locked;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            s_locked_wr |=> $stable(sp_r[0]) && $stable(sp_r[1]) && $stable(sp_r[2]);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write changed a register");
    property p_one_shot;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            s_unlocked_wr |=> key_r == 8'h00 && sp_r[$past(ptr_idx)] == ($past(sh_r) & 8'hBF);
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("unlocked write not single-shot");
    property p_key_expire;
        @(posedge clk_sys_i) disable iff (!rst_n_i) txn_end && !fresh_r |=> key_r == 8'h00;
    endproperty
    a_key_expire: assert property (p_key_expire) else $error("unlock key outlived next transaction");

endmodule
`default_nettype wire

// [rtl/bvs_pkg.sv]
// Constants for the step-down converter setpoint register bank.
// Assumes a single 100 MHz system clock and a two-wire serial management bus.
package bvs_pkg;

    // ***********************************************************
    // Serial bus and register map
    // ***********************************************************
    localparam logic [6:0] BVS_DEV_ADDR = 7'h24;
    localparam logic [7:0] BVS_OFS_BUCK1 = 8'h0E;
    localparam logic [7:0] BVS_OFS_BUCK2 = 8'h0F;
    localparam logic [7:0] BVS_OFS_BUCK3 = 8'h10;
    localparam logic [7:0] BVS_OFS_UNLOCK = 8'h0B;
    localparam logic [7:0] BVS_UNLOCK_KEY = 8'h7D;
    localparam logic [7:0] BVS_UNLOCK_RST = 8'h00;
    localparam logic [3:0] BVS_BITS_PER_BYTE = 4'h8;

    // ***********************************************************
    // Field layout of a setpoint control register
    // ***********************************************************
    localparam int BVS_EXT_ADJ_BIT = 7;
    localparam int BVS_RSVD_BIT = 6;
    localparam logic [7:0] BVS_WR_MASK = 8'hBF;

    // ***********************************************************
    // Reset values, indexed by device variant 0..3
    // ***********************************************************
    localparam logic [7:0] BVS_BUCK1_RST [0:3] = '{8'h1E, 8'h1E, 8'h18, 8'h12};
    localparam logic [7:0] BVS_BUCK2_RST [0:3] = '{8'h38, 8'h08, 8'h08, 8'h08};
    localparam logic [7:0] BVS_BUCK3_RST = 8'h08;

    // ***********************************************************
    // Code to millivolt table
    // ***********************************************************
    localparam logic [5:0] BVS_CODE_MID = 6'h18;
    localparam logic [5:0] BVS_CODE_TOP = 6'h30;
    localparam logic [5:0] BVS_CODE_SAT = 6'h38;
    localparam logic [11:0] BVS_LO_BASE_MV = 12'h384;
    localparam logic [11:0] BVS_LO_STEP_MV = 12'h019;
    localparam logic [11:0] BVS_MID_BASE_MV = 12'h5DC;
    localparam logic [11:0] BVS_MID_STEP_MV = 12'h032;
    localparam logic [11:0] BVS_SAT_MV = 12'hCE4;
    localparam logic [11:0] BVS_TOP_MV [0:7] = '{12'hA8C, 12'hABE, 12'hAF0, 12'hB22,
                                                 12'hB54, 12'hBB8, 12'hC1C, 12'hC80};

endpackage

// [rtl/bvs_code_to_mv.sv]
// Decodes a 6-bit converter setpoint code into its target voltage in millivolts.
// Assumes the code comes from logic on the same clock; the result is one cycle late.
`timescale 1ns/1ps
`default_nettype none
module bvs_code_to_mv (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [5:0] code_i,
    output logic [11:0] mv_o
);
    logic [11:0] mv_r;
    logic [11:0] mv_nxt;
    logic [5:0] ofs;

    // ***********************************************************
    // Piecewise table
    // ***********************************************************
    always_comb begin
        ofs = 6'h00;
        if (code_i < bvs_pkg::BVS_CODE_MID) begin
            mv_nxt = 12'(bvs_pkg::BVS_LO_BASE_MV + bvs_pkg::BVS_LO_STEP_MV * code_i);
        end else if (code_i < bvs_pkg::BVS_CODE_TOP) begin
            ofs = 6'(code_i - bvs_pkg::BVS_CODE_MID);
            mv_nxt = 12'(bvs_pkg::BVS_MID_BASE_MV + bvs_pkg::BVS_MID_STEP_MV * ofs);
        end else if (code_i < bvs_pkg::BVS_CODE_SAT) begin
            mv_nxt = bvs_pkg::BVS_TOP_MV[code_i[2:0]];
        end else begin
            mv_nxt = bvs_pkg::BVS_SAT_MV;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mv_r <= 12'h000;
        end else begin
            mv_r <= mv_nxt;
        end
    end

    assign mv_o = mv_r;

    // ***********************************************************
    // Checks
    // ***********************************************************
    property p_code_zero;
        @(posedge clk_sys_i) disable iff (!rst_n_i) (code_i == 6'h00) |=> (mv_o == 12'h384);
    endproperty
    a_code_zero: assert property (p_code_zero) else $error("code 0 is not 0.9 V");

    property p_lo_end;
        @(posedge clk_sys_i) disable iff (!rst_n_i) (code_i == 6'h17) |=> (mv_o == 12'h5C3);
    endproperty
    a_lo_end: assert property (p_lo_end) else $error("code 23 is not 1.475 V");

    property p_mid_span;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            ((code_i == 6'h18) |=> (mv_o == 12'h5DC)) and ((code_i == 6'h2F) |=> (mv_o == 12'hA5A));
    endproperty
    a_mid_span: assert property (p_mid_span) else $error("middle range end points wrong");

    property p_top_table;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            (code_i == 6'h35) |=> (mv_o == 12'hBB8);
    endproperty
    a_top_table: assert property (p_top_table) else $error("code 53 is not 3.0 V");

    property p_saturate;
        @(posedge clk_sys_i) disable iff (!rst_n_i) (code_i >= 6'h38) |=> (mv_o == 12'hCE4);
    endproperty
    a_saturate: assert property (p_saturate) else $error("top codes do not saturate at 3.3 V");

endmodule
`default_nettype wire

// [testbench/bvs_host_model.sv]
// Host processor model that drives the two-wire management bus of the setpoint bank.
// Assumes a pull-up on the data line and a device that pulls low while sda_oe_i is high.
`timescale 1ns/1ps
`default_nettype none
module bvs_host_model (
    input wire logic clk_sys_i,
    input wire logic sda_oe_i,
    input wire logic dev_sda_i,
    output logic scl_o,
    output logic sda_o
);
    logic scl_r = 1'b1;
    logic sda_r = 1'b1;
    assign scl_o = scl_r;
    // Pull-up wins unless a party pulls low
    assign sda_o = sda_oe_i ? (sda_r & dev_sda_i) : sda_r;

    // ***********************************************************
    // Bus phases, eight system clocks per phase, three phases per bit
    // ***********************************************************
    task automatic half();
        repeat (8) @(posedge clk_sys_i);
    endtask

    task automatic start_cond();
        sda_r <= 1'b1;
        half();
        scl_r <= 1'b1;
        half();
        sda_r <= 1'b0;
        half();
        scl_r <= 1'b0;
        half();
    endtask

    task automatic stop_cond();
        sda_r <= 1'b0;
        half();
        scl_r <= 1'b1;
        half();
        sda_r <= 1'b1;
        half();
    endtask

    // Data moves only while the clock is low, so no false start or stop
    task automatic xfer_bit(input logic b, output logic r);
        sda_r <= b;
        half();
        scl_r <= 1'b1;
        half();
        r = sda_o;
        scl_r <= 1'b0;
        half();
    endtask

    task automatic put_byte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
    endtask

    // Single-byte reads end with a not-acknowledge
    task automatic get_byte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(1'b1, r);
    endtask

    task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
        start_cond();
        put_byte({bvs_pkg::BVS_DEV_ADDR, 1'b0});
        put_byte(ofs);
        put_byte(d);
        stop_cond();
    endtask

    // Key first, then the protected write in the very next transaction
    task automatic guarded_write(input logic [7:0] ofs, input logic [7:0] d);
        reg_write(bvs_pkg::BVS_OFS_UNLOCK, bvs_pkg::BVS_UNLOCK_KEY);
        reg_write(ofs, d);
    endtask

    task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d);
        start_cond();
        put_byte({bvs_pkg::BVS_DEV_ADDR, 1'b0});
        put_byte(ofs);
        start_cond();
        put_byte({bvs_pkg::BVS_DEV_ADDR, 1'b1});
        get_byte(d);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// [testbench/test_buck_voltage_setpoint_regs.sv]
// Self-checking bench for the converter setpoint register bank, variant 0.
// Assumes the host model in bvs_host_model.sv and a 100 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module test_buck_voltage_setpoint_regs;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic scl;
    logic sda;
    logic dev_sda;
    logic sda_oe;
    logic adj [1:3];
    logic [5:0] code [1:3];
    logic [11:0] mv [1:3];
    int miscompares = 0;
    int checked = 0;
    logic [7:0] d;

    always #5 clk_sys_i = ~clk_sys_i;

    bvs_host_model i_host (.clk_sys_i(clk_sys_i), .sda_oe_i(sda_oe), .dev_sda_i(dev_sda), .scl_o(scl), .sda_o(sda));

    bvs_setpoint_regs #(.VARIANT(0)) i_dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(dev_sda), .sda_oe_o(sda_oe),
        .buck1_external_adjust_o(adj[1]), .buck1_voltage_code_o(code[1]), .buck1_voltage_mv_o(mv[1]),
        .buck2_external_adjust_o(adj[2]), .buck2_voltage_code_o(code[2]), .buck2_voltage_mv_o(mv[2]),
        .buck3_external_adjust_o(adj[3]), .buck3_voltage_code_o(code[3]), .buck3_voltage_mv_o(mv[3]));

    // ***********************************************************
    // Checking helpers
    // ***********************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask

    function automatic logic [11:0] exp_mv(input logic [5:0] c);
        logic [11:0] top [0:7];
        top = '{12'hA8C, 12'hABE, 12'hAF0, 12'hB22, 12'hB54, 12'hBB8, 12'hC1C, 12'hC80};
        if (c < 6'h18) return 12'h384 + 12'h019 * {6'h00, c};
        if (c < 6'h30) return 12'h5DC + 12'h032 * {6'h00, c - 6'h18};
        if (c < 6'h38) return top[c[2:0]];
        return 12'hCE4;
    endfunction

    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ***********************************************************
    // Scenarios
    // ***********************************************************
    task automatic t_reset();
        logic [7:0] rst_v [1:3];
        logic [11:0] rst_mv [1:3];
        rst_v = '{8'h1E, 8'h38, 8'h08};
        rst_mv = '{12'h708, 12'hCE4, 12'h44C};
        for (int b = 1; b <= 3; b++) begin
            i_host.reg_read(8'(8'h0D + b), d);
            chk(16'(d), 16'(rst_v[b]));
            chk(16'(mv[b]), 16'(rst_mv[b]));
            chk(16'(adj[b]), 16'h0000);
        end
        $display("test reset done");
    endtask

    task automatic t_locked();
        i_host.reg_write(8'h10, 8'h2A);
        i_host.reg_read(8'h10, d);
        chk(16'(d), 16'h0008);
        chk(16'(code[3]), 16'h0008);
        $display("test locked done");
    endtask

    task automatic t_unlock();
        i_host.guarded_write(8'h10, 8'hEA);
        i_host.reg_read(8'h10, d);
        chk(16'(d), 16'h00AA);
        chk(16'(adj[3]), 16'h0001);
        chk(16'(code[3]), 16'h002A);
        i_host.reg_write(8'h10, 8'h05);
        i_host.reg_read(8'h10, d);
        chk(16'(d), 16'h00AA);
        i_host.guarded_write(8'h10, 8'h2A);
        chk(16'(adj[3]), 16'h0000);
        $display("test unlock done");
    endtask

    task automatic t_wrong_key();
        logic [7:0] keys [0:3];
        keys = '{8'h7C, 8'h7E, 8'hFF, 8'h00};
        foreach (keys[k]) begin
            i_host.reg_write(bvs_pkg::BVS_OFS_UNLOCK, keys[k]);
            i_host.reg_write(8'h10, 8'h11);
            i_host.reg_read(8'h10, d);
            chk(16'(d), 16'h002A);
        end
        $display("test wrong key done");
    endtask

    // An unrelated transaction between key and write lets the key lapse
    task automatic t_expiry();
        i_host.reg_write(bvs_pkg::BVS_OFS_UNLOCK, bvs_pkg::BVS_UNLOCK_KEY);
        i_host.reg_read(8'h0E, d);
        i_host.reg_write(8'h10, 8'h01);
        i_host.reg_read(8'h10, d);
        chk(16'(d), 16'h002A);
        i_host.reg_read(bvs_pkg::BVS_OFS_UNLOCK, d);
        chk(16'(d), 16'h0000);
        $display("test expiry done");
    endtask

    task automatic t_table();
        logic [5:0] codes [0:10];
        int b;
        // Last entry lands on buck2, so its code-zero path is exercised too
        codes = '{6'h00, 6'h01, 6'h17, 6'h18, 6'h2F, 6'h30, 6'h35, 6'h37, 6'h38, 6'h3F, 6'h00};
        foreach (codes[i]) begin
            b = 1 + i % 3;
            i_host.guarded_write(8'(8'h0D + b), {2'b00, codes[i]});
            chk(16'(code[b]), 16'(codes[i]));
            chk(16'(mv[b]), 16'(exp_mv(codes[i])));
        end
        $display("test table done");
    endtask

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        t_reset();
        t_locked();
        t_unlock();
        t_wrong_key();
        t_expiry();
        t_table();
        end_sim();
    end

    // Scenarios need about 39000 cycles
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        miscompares++;
        $display("watchdog expired at %0t", $time);
        end_sim();
    end
endmodule
`default_nettype wire
